/* File: src/ast_pkg.sv */
package ast_pkg;
   // ------------------------------------------------------------
   // register offsets on the byte-wide register port
   // ------------------------------------------------------------
   localparam logic [7:0] PERIPH_IRQ_FLAGS_ADDR = 8'h0C;
   localparam logic [7:0] RX_STATUS_CONTROL_ADDR = 8'h18;
   localparam logic [7:0] TX_HOLDING_BUFFER_ADDR = 8'h19;
   localparam logic [7:0] RX_FIFO_READ_ADDR = 8'h1A;
   localparam logic [7:0] PERIPH_IRQ_ENABLES_ADDR = 8'h8C;
   localparam logic [7:0] TX_STATUS_CONTROL_ADDR = 8'h98;
   localparam logic [7:0] BAUD_DIVISOR_ADDR = 8'h99;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   // tx_status_control
   localparam int TXS_CLK_SRC = 7;
   localparam int TXS_NINE = 6;
   localparam int TXS_TX_EN = 5;
   localparam int TXS_SYNC = 4;
   localparam int TXS_HIGH_SPEED = 2;
   localparam int TXS_SHIFT_EMPTY = 1;
   localparam int TXS_NINTH_BIT = 0;
   // rx_status_control
   localparam int RXS_PORT_EN = 7;
   localparam int RXS_NINE = 6;
   localparam int RXS_SINGLE_EN = 5;
   localparam int RXS_CONT_EN = 4;
   localparam int RXS_FRAMING = 2;
   localparam int RXS_OVERRUN = 1;
   localparam int RXS_NINTH_BIT = 0;
   // flag and enable registers
   localparam int IRQ_RX_READY = 5;
   localparam int IRQ_TX_EMPTY = 4;
   // ------------------------------------------------------------
   // reset values and timing counts
   // ------------------------------------------------------------
   localparam logic [7:0] TX_STATUS_RESET = 8'h02;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [1:0] LOW_SPEED_PRESCALE_LAST = 2'h3; // x64 = x16 times 4
   localparam logic [3:0] SAMPLES_LAST = 4'hF; // sixteen samples per bit
   localparam logic [3:0] VOTE_A = 4'h7; // three votes near mid-bit
   localparam logic [3:0] VOTE_B = 4'h8;
   localparam logic [3:0] VOTE_C = 4'h9;
   localparam logic [3:0] LAST_BIT_8 = 4'h7;
   localparam logic [3:0] LAST_BIT_9 = 4'h8;
   localparam logic [1:0] RX_FIFO_DEPTH = 2'h2;
   // line state machine, shared by transmit and receive
   typedef enum logic [3:0] {
      LN_IDLE = 4'h1,
      LN_START = 4'h2,
      LN_DATA = 4'h4,
      LN_STOP = 4'h8
   } ast_line_e;
endpackage

/* File: src/ast_uart.sv */
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ns
// Overview of operation
// - start, eight or nine data, one stop
// - data bits least significant first
// - transmit and receive independent, shared baud rate
// - baud output x16 high speed, x64 low
// - no hardware parity; ninth bit carries it
// - baud timer and both line sequencers halt during sleep
// - async when sync clear and port enabled
// - shifter reloads only after stop bit sent
// - empty flag ignores software, cleared by write
// - shift-empty status bit, read only, no interrupt
// - transmit enable sets empty flag
// - start needs data only, no baud tick wait
// - write to empty shifter transfers at once
// - clearing transmit enable aborts, pin released
// - ninth transmit bit latched at transfer
// - receive sampled at sixteen per bit
// - continuous receive enable turns receiver on
// - after stop, word into fifo, ready flag
// - ready flag read only, clears when empty
// - two-word fifo, third word sets overrun
// - overrun blocks fifo until enable toggled
// - framing error and ninth bit queued per word
// - rate is clock over 64(divisor+1) or 16(divisor+1)
// - divisor write clears baud timer
// - bit decided by three-sample majority
module ast_uart (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // register port
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // power state and request
   input wire logic sleep_i,
   output logic irq_o,
   // serial line
   input wire logic rx_pin_i,
   output logic tx_pin_o,
   output logic tx_pin_oe_o
);
   // ------------------------------------------------------------
   // decoding helpers
   // ------------------------------------------------------------
   // majority of three votes
   function automatic logic maj3(input logic a, input logic b, input logic c);
      maj3 = (a & b) | (a & c) | (b & c);
   endfunction
   // last data bit index for the frame length
   function automatic logic [3:0] last_bit(input logic nine);
      last_bit = nine ? ast_pkg::LAST_BIT_9 : ast_pkg::LAST_BIT_8;
   endfunction

   // ------------------------------------------------------------
   // software registers
   // ------------------------------------------------------------
   logic [7:0] txs_q; // tx_status_control, shift-empty bit computed
   logic [7:0] rxs_q; // rx_status_control, status bits computed
   logic [7:0] pie_q; // periph_irq_enables
   logic [7:0] div_q; // baud_divisor
   logic [7:0] hold_q; // tx_holding_buffer
   logic hold_full_q; // holding buffer has a word
   logic tx_buffer_empty_flag_q; // tx_buffer_empty_flag
   logic [7:0] rdata_q;
   logic irq_q;
   // strobes
   wire wr_txs_w = wr_i & (addr_i == ast_pkg::TX_STATUS_CONTROL_ADDR);
   wire wr_rxs_w = wr_i & (addr_i == ast_pkg::RX_STATUS_CONTROL_ADDR);
   wire wr_pie_w = wr_i & (addr_i == ast_pkg::PERIPH_IRQ_ENABLES_ADDR);
   wire wr_div_w = wr_i & (addr_i == ast_pkg::BAUD_DIVISOR_ADDR);
   wire wr_hold_w = wr_i & (addr_i == ast_pkg::TX_HOLDING_BUFFER_ADDR);
   wire rd_fifo_w = rd_i & (addr_i == ast_pkg::RX_FIFO_READ_ADDR);
   // mode bits
   wire tx_en_w = txs_q[ast_pkg::TXS_TX_EN];
   wire cont_en_w = rxs_q[ast_pkg::RXS_CONT_EN];
   wire high_speed_w = txs_q[ast_pkg::TXS_HIGH_SPEED];
   wire async_on_w = rxs_q[ast_pkg::RXS_PORT_EN] & ~txs_q[ast_pkg::TXS_SYNC];
   wire tx_enable_rise_w = wr_txs_w & wdata_i[ast_pkg::TXS_TX_EN] & ~tx_en_w;

   // ------------------------------------------------------------
   // baud generator
   // ------------------------------------------------------------
   logic [1:0] pre_q; // low speed prescaler
   logic [7:0] brg_q; // baud timer
   // timer kept cleared while neither direction is enabled
   wire brg_clr_w = ~(async_on_w & (tx_en_w | cont_en_w)) | wr_div_w;
   // sleep freezes the timer without clearing it
   wire brg_run_w = ~brg_clr_w & ~sleep_i;
   // x16 straight, x64 through the four-step prescaler
   wire pre_tick_w = high_speed_w | (pre_q == ast_pkg::LOW_SPEED_PRESCALE_LAST);
   // one sample tick per (divisor+1) timer steps
   wire tick_w = brg_run_w & pre_tick_w & (brg_q == div_q);
   // prescaler and timer
   always_ff @(posedge clk_i) begin
      // divisor write clears the timer at once
      if (rst_i | brg_clr_w) begin
         pre_q <= 2'h0;
         brg_q <= 8'h00;
      end else if (brg_run_w) begin
         pre_q <= pre_q + 2'h1;
         if (pre_tick_w) begin
            brg_q <= tick_w ? 8'h00 : brg_q + 8'h01;
         end
      end
   end

   // ------------------------------------------------------------
   // transmitter
   // ------------------------------------------------------------
   ast_pkg::ast_line_e tx_st_q;
   logic [8:0] tsr_q; // tx_shift_register
   logic [3:0] tx_ph_q; // sample tick within a bit
   logic [3:0] tx_bit_q; // data bit index
   logic tx_line_q;
   logic tx_oe_q;
   wire tx_idle_w = (tx_st_q == ast_pkg::LN_IDLE);
   wire tx_bit_end_w = tick_w & (tx_ph_q == ast_pkg::SAMPLES_LAST);
   // load only with the shifter idle after the stop bit
   // an idle shifter takes a fresh word on the next edge
   wire tx_load_w = async_on_w & tx_en_w & hold_full_q & tx_idle_w & ~sleep_i;
   // clearing the enable resets the shifter
   wire tx_abort_w = ~tx_en_w | ~async_on_w;
   // holding buffer and its empty flag
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hold_q <= ast_pkg::REG_RESET;
         hold_full_q <= 1'b0;
         tx_buffer_empty_flag_q <= 1'b0;
      end else begin
         if (wr_hold_w) begin
            hold_q <= wdata_i;
         end
         // a write beside a transfer keeps the buffer full
         hold_full_q <= wr_hold_w | (hold_full_q & ~tx_load_w);
         // only a buffer write clears; software cannot
         if (wr_hold_w) begin
            tx_buffer_empty_flag_q <= 1'b0;
         // flag rises the cycle after the transfer
         // enabling the transmitter sets it too
         end else if (tx_load_w | tx_enable_rise_w) begin
            tx_buffer_empty_flag_q <= 1'b1;
         end
      end
   end
   // transmit line sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i | tx_abort_w) begin
         tx_st_q <= ast_pkg::LN_IDLE;
         tsr_q <= 9'h000;
         tx_ph_q <= 4'h0;
         tx_bit_q <= 4'h0;
      end else begin
         // the frame then paces itself on baud ticks
         if (tick_w & ~tx_idle_w) begin
            tx_ph_q <= tx_ph_q + 4'h1;
         end
         case (tx_st_q)
            ast_pkg::LN_IDLE: begin
               if (tx_load_w) begin
                  // ninth bit taken from the control register now
                  tsr_q <= {txs_q[ast_pkg::TXS_NINTH_BIT], hold_q};
                  tx_ph_q <= 4'h0;
                  tx_bit_q <= 4'h0;
                  tx_st_q <= ast_pkg::LN_START;
               end
            end
            ast_pkg::LN_START: begin
               if (tx_bit_end_w) begin
                  tx_st_q <= ast_pkg::LN_DATA;
               end
            end
            ast_pkg::LN_DATA: begin
               // shift right so bit 0 leaves first
               if (tx_bit_end_w) begin
                  tsr_q <= {1'b0, tsr_q[8:1]};
                  tx_bit_q <= tx_bit_q + 4'h1;
                  // nine bits go out as stored, no parity made
                  if (tx_bit_q == last_bit(txs_q[ast_pkg::TXS_NINE])) begin
                     tx_st_q <= ast_pkg::LN_STOP;
                  end
               end
            end
            ast_pkg::LN_STOP: begin
               if (tx_bit_end_w) begin
                  tx_st_q <= ast_pkg::LN_IDLE;
               end
            end
            default: begin
               tx_st_q <= ast_pkg::LN_IDLE;
            end
         endcase
      end
   end
   // idle line held high while enabled
   wire tx_line_w = (tx_st_q == ast_pkg::LN_START) ? 1'b0 :
                    (tx_st_q == ast_pkg::LN_DATA) ? tsr_q[0] : 1'b1;
   // pin drivers, registered so the pins never glitch
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_line_q <= 1'b1;
         tx_oe_q <= 1'b0;
      end else begin
         tx_line_q <= tx_line_w;
         // pin released whenever transmit is off
         tx_oe_q <= ~tx_abort_w;
      end
   end

   // ------------------------------------------------------------
   // receiver
   // ------------------------------------------------------------
   ast_pkg::ast_line_e rx_st_q;
   logic [8:0] rsr_q; // rx_shift_register
   logic [3:0] rx_ph_q;
   logic [3:0] rx_bit_q;
   logic rx_prev_q; // last line level, for edge detect
   logic va_q; // first vote
   logic vb_q; // second vote
   logic overrun_error_q; // overrun_error
   logic [9:0] fifo_q [0:1]; // {framing, ninth, data}
   logic wp_q;
   logic rp_q;
   logic [1:0] cnt_q;
   // receiver runs only with continuous enable
   wire rx_on_w = async_on_w & cont_en_w;
   wire rx_idle_w = (rx_st_q == ast_pkg::LN_IDLE);
   // a falling edge on the idle line opens a frame
   wire rx_fall_w = rx_on_w & rx_idle_w & rx_prev_q & ~rx_pin_i & ~sleep_i;
   // sixteen sample ticks make one receive bit
   wire rx_bit_end_w = tick_w & (rx_ph_q == ast_pkg::SAMPLES_LAST);
   wire rx_vote_w = tick_w & (rx_ph_q == ast_pkg::VOTE_C);
   wire rx_bit_w = maj3(va_q, vb_q, rx_pin_i);
   wire rx_stop_w = rx_vote_w & (rx_st_q == ast_pkg::LN_STOP);
   wire fifo_full_w = (cnt_q == ast_pkg::RX_FIFO_DEPTH);
   // word enters the fifo once the stop bit is sampled
   wire push_w = rx_stop_w & ~overrun_error_q & ~fifo_full_w;
   wire ovr_set_w = rx_stop_w & ~overrun_error_q & fifo_full_w;
   wire pop_w = rd_fifo_w & (cnt_q != 2'h0);
   wire [9:0] head_w = fifo_q[rp_q];
   // receive line sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i | ~rx_on_w) begin
         rx_st_q <= ast_pkg::LN_IDLE;
         rsr_q <= 9'h000;
         rx_ph_q <= 4'h0;
         rx_bit_q <= 4'h0;
         va_q <= 1'b1;
         vb_q <= 1'b1;
      end else begin
         if (tick_w & ~rx_idle_w) begin
            rx_ph_q <= rx_ph_q + 4'h1;
         end
         if (tick_w & (rx_ph_q == ast_pkg::VOTE_A)) begin
            va_q <= rx_pin_i;
         end
         if (tick_w & (rx_ph_q == ast_pkg::VOTE_B)) begin
            vb_q <= rx_pin_i;
         end
         case (rx_st_q)
            ast_pkg::LN_IDLE: begin
               if (rx_fall_w) begin
                  rx_ph_q <= 4'h0;
                  rx_bit_q <= 4'h0;
                  rsr_q <= 9'h000;
                  rx_st_q <= ast_pkg::LN_START;
               end
            end
            ast_pkg::LN_START: begin
               // a start bit that votes high was a glitch
               if (rx_vote_w & rx_bit_w) begin
                  rx_st_q <= ast_pkg::LN_IDLE;
               end else if (rx_bit_end_w) begin
                  rx_st_q <= ast_pkg::LN_DATA;
               end
            end
            ast_pkg::LN_DATA: begin
               // first data bit lands in bit 0
               if (rx_vote_w) begin
                  rsr_q[rx_bit_q] <= rx_bit_w;
               end
               if (rx_bit_end_w) begin
                  rx_bit_q <= rx_bit_q + 4'h1;
                  // frame length follows the nine-bit select
                  if (rx_bit_q == last_bit(rxs_q[ast_pkg::RXS_NINE])) begin
                     rx_st_q <= ast_pkg::LN_STOP;
                  end
               end
            end
            ast_pkg::LN_STOP: begin
               // back to idle at mid-stop so the next edge is caught
               if (rx_vote_w) begin
                  rx_st_q <= ast_pkg::LN_IDLE;
               end
            end
            default: begin
               rx_st_q <= ast_pkg::LN_IDLE;
            end
         endcase
      end
   end
   // line history for the edge detector
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_prev_q <= 1'b1;
      end else if (~sleep_i) begin
         rx_prev_q <= rx_pin_i;
      end
   end
   // receive fifo and overrun
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fifo_q[0] <= 10'h000;
         fifo_q[1] <= 10'h000;
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         cnt_q <= 2'h0;
         overrun_error_q <= 1'b0;
      end else begin
         // framing error and ninth bit stored with the word
         if (push_w) begin
            fifo_q[wp_q] <= {~rx_bit_w,
                             rsr_q[8] & rxs_q[ast_pkg::RXS_NINE], rsr_q[7:0]};
            wp_q <= ~wp_q;
         end
         if (pop_w) begin
            rp_q <= ~rp_q;
         end
         cnt_q <= cnt_q + {1'b0, push_w} - {1'b0, pop_w};
         // only turning the receiver off (receive or port enable cleared, or sync set) clears overrun
         if (~rx_on_w) begin
            overrun_error_q <= 1'b0;
         // third word is dropped and flagged
         end else if (ovr_set_w) begin
            overrun_error_q <= 1'b1;
         end
      end
   end
   // ready flag follows fifo occupancy, never written
   wire rx_ready_flag_w = (cnt_q != 2'h0);

   // ------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------
   // control registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         txs_q <= ast_pkg::TX_STATUS_RESET;
         rxs_q <= ast_pkg::REG_RESET;
         pie_q <= ast_pkg::REG_RESET;
         div_q <= ast_pkg::REG_RESET;
      end else begin
         // the shift-empty bit is not writable
         if (wr_txs_w) begin
            txs_q <= {wdata_i[7:4], 1'b0, wdata_i[2], 1'b0, wdata_i[0]};
         end
         // status bits of the receive register are computed
         if (wr_rxs_w) begin
            rxs_q <= {wdata_i[7:4], 4'h0};
         end
         if (wr_pie_w) begin
            pie_q <= wdata_i;
         end
         if (wr_div_w) begin
            div_q <= wdata_i;
         end
      end
   end

   // ------------------------------------------------------------
   // register reads
   // ------------------------------------------------------------
   // shift-empty reads one while the shifter is idle
   wire [7:0] txs_rd_w = {txs_q[7:4], 1'b0, txs_q[2], tx_idle_w, txs_q[0]};
   // head-of-fifo status, updated by each fifo read
   wire [7:0] rxs_rd_w = {rxs_q[7:4], 1'b0, head_w[9] & rx_ready_flag_w, overrun_error_q,
                          head_w[8] & rx_ready_flag_w};
   wire [7:0] pir_rd_w = {2'h0, rx_ready_flag_w, tx_buffer_empty_flag_q, 4'h0};
   wire [7:0] fifo_rd_w = rx_ready_flag_w ? head_w[7:0] : 8'h00;
   wire [7:0] rd_mux_w =
      (addr_i == ast_pkg::PERIPH_IRQ_FLAGS_ADDR) ? pir_rd_w :
      (addr_i == ast_pkg::RX_STATUS_CONTROL_ADDR) ? rxs_rd_w :
      (addr_i == ast_pkg::TX_HOLDING_BUFFER_ADDR) ? hold_q :
      (addr_i == ast_pkg::RX_FIFO_READ_ADDR) ? fifo_rd_w :
      (addr_i == ast_pkg::PERIPH_IRQ_ENABLES_ADDR) ? pie_q :
      (addr_i == ast_pkg::TX_STATUS_CONTROL_ADDR) ? txs_rd_w :
      (addr_i == ast_pkg::BAUD_DIVISOR_ADDR) ? div_q : 8'h00;
   // request output gated by the enables
   wire irq_w = (rx_ready_flag_w & pie_q[ast_pkg::IRQ_RX_READY]) |
                (tx_buffer_empty_flag_q & pie_q[ast_pkg::IRQ_TX_EMPTY]);
   // read data valid only in the cycle after the strobe
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_q <= 8'h00;
         irq_q <= 1'b0;
      end else begin
         rdata_q <= rd_i ? rd_mux_w : 8'h00;
         irq_q <= irq_w;
      end
   end
   assign rdata_o = rdata_q;
   assign irq_o = irq_q;
   assign tx_pin_o = tx_line_q;
   assign tx_pin_oe_o = tx_oe_q;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_tx_buffer_empty_flag_write_clear: assert property (wr_hold_w |=> !tx_buffer_empty_flag_q)
      else $error("empty flag not cleared by buffer write");
   chk_tx_buffer_empty_flag_enable_set: assert property ($rose(tx_en_w) |-> tx_buffer_empty_flag_q)
      else $error("empty flag not set by transmit enable");
   chk_tx_load_idle: assert property (tx_load_w |=> tx_st_q == ast_pkg::LN_START ##1 !tx_idle_w)
      else $error("shifter load mistimed");
   chk_tx_abort_pin: assert property ($fell(tx_en_w) |=> !tx_pin_oe_o && tx_idle_w)
      else $error("abort did not release pin");
   chk_ovr_blocks: assert property (overrun_error_q && rx_stop_w |=> $stable(cnt_q) || cnt_q < $past(cnt_q))
      else $error("fifo written during overrun");
   chk_ovr_full: assert property (ovr_set_w |=> overrun_error_q && cnt_q == 2'h2)
      else $error("overrun not raised on full fifo");
   chk_sleep_halt: assert property (sleep_i |=> $stable(tx_ph_q) && $stable(rx_ph_q))
      else $error("line logic ran during sleep");
   chk_brg_clear: assert property (wr_div_w |=> brg_q == 8'h00 && pre_q == 2'h0)
      else $error("baud timer not cleared");
   chk_rx_ready_flag_drain: assert property (pop_w && cnt_q == 2'h1 && !push_w |=> !rx_ready_flag_w)
      else $error("ready flag stuck after drain");
   cov_tx_load: cover property (tx_load_w ##1 wr_hold_w);
   cov_rx_push: cover property (push_w);
   cov_rx_overrun: cover property (ovr_set_w);
endmodule

/* File: tb/ast_peer.sv */
`timescale 1ns/1ns
// -----------------------------------------------------------------
// remote serial peer: sends frames on the receive line and decodes
// frames seen on the transmit line
// -----------------------------------------------------------------
module ast_peer (
   // clock
   input wire logic clk_i,
   // line from the block, after the pull-up
   input wire logic line_i,
   // line into the block
   output logic line_o
);
   int bit_clks = 16; // clocks per bit, set by the bench to match the divisor
   initial line_o = 1'b1; // idle high between frames
   task automatic send(input logic [8:0] w, input int n, input logic stop);
      line_o <= 1'b0;
      repeat (bit_clks) @(posedge clk_i);
      for (int i = 0; i < n; i++) begin
         line_o <= w[i];
         repeat (bit_clks) @(posedge clk_i);
      end
      line_o <= stop; // a low stop is only sent on request
      repeat (bit_clks) @(posedge clk_i);
      line_o <= 1'b1;
      // one idle edge so a low stop is followed by a real falling edge
      @(posedge clk_i);
   endtask
   // mid-bit decode, bounded wait for the start
   task automatic recv(input int n, output logic [8:0] w, output logic ok);
      int t;
      t = 0;
      w = 9'h000;
      while (line_i !== 1'b0 && t < 4000) begin
         @(posedge clk_i);
         t++;
      end
      ok = (t < 4000);
      repeat (bit_clks / 2) @(posedge clk_i);
      for (int i = 0; i < n; i++) begin
         repeat (bit_clks) @(posedge clk_i);
         w[i] = line_i;
      end
      repeat (bit_clks) @(posedge clk_i);
      // a stop bit that is not high is a broken frame
      if (line_i !== 1'b1) ok = 1'b0;
   endtask
endmodule

/* File: tb/async_serial_transceiver_bench.sv */
`timescale 1ns/1ns
module async_serial_transceiver_bench;
   // -----------------------------------------------------------------
   // stimulus and observed signals
   // -----------------------------------------------------------------
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic sleep_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic [7:0] rdata_o;
   logic irq_o;
   logic tx_pin_o;
   logic tx_pin_oe_o;
   logic rx_line;
   int err_total = 0;
   int compares = 0;
   logic [7:0] ra [8] = '{8'h0C, 8'h18, 8'h19, 8'h1A, 8'h8C, 8'h98, 8'h99, 8'h40};
   // released transmit pin is pulled high at the peer
   wire logic tx_line = tx_pin_oe_o ? tx_pin_o : 1'b1;
   initial forever #20 clk_i = ~clk_i;
   ast_uart uut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sleep_i(sleep_i), .irq_o(irq_o),
      .rx_pin_i(rx_line), .tx_pin_o(tx_pin_o), .tx_pin_oe_o(tx_pin_oe_o));
   ast_peer peer (.clk_i(clk_i), .line_i(tx_line), .line_o(rx_line));
   // -----------------------------------------------------------------
   // access and compare tasks; wr and rdc end one idle edge after their strobe
   // -----------------------------------------------------------------
   task automatic chk(input string what, input logic [8:0] e, input logic [8:0] g);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(posedge clk_i);
      chk($sformatf("reg %h", a), {1'b0, e}, {1'b0, rdata_o});
   endtask
   task automatic getw(input int n, input logic [8:0] e);
      logic [8:0] w;
      logic ok;
      peer.recv(n, w, ok);
      // a frame that never came ends the run
      if (!ok) begin
         err_total++;
         tally_and_finish();
      end
      chk("tx word", e, w);
   endtask
   task automatic tally_and_finish();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      // reset values, unmapped address last
      foreach (ra[i]) rdc(ra[i], (ra[i] == 8'h98) ? 8'h02 : 8'h00);
      wr(8'h99, 8'h00);
      wr(8'h18, 8'h90);
      wr(8'h98, 8'h24);
      rdc(8'h0C, 8'h10);
      wr(8'h0C, 8'h00);
      rdc(8'h0C, 8'h10);
      wr(8'h8C, 8'h10);
      // request output is registered one edge behind the enable
      @(posedge clk_i);
      chk("irq", 9'h001, {8'h00, irq_o});
      // back to back: the first word moves at once, the second waits
      wr(8'h19, 8'hA5);
      wr(8'h19, 8'h3C);
      rdc(8'h0C, 8'h00);
      getw(8, 9'h0A5);
      getw(8, 9'h03C);
      repeat (16) @(posedge clk_i);
      rdc(8'h98, 8'h26);
      wr(8'h98, 8'h65);
      wr(8'h19, 8'h81);
      getw(9, 9'h181);
      wr(8'h98, 8'h24);
      // three words into a two-word fifo
      peer.send(9'h05A, 8, 1'b1);
      peer.send(9'h0C3, 8, 1'b1);
      peer.send(9'h011, 8, 1'b1);
      rdc(8'h0C, 8'h30);
      rdc(8'h18, 8'h92);
      rdc(8'h1A, 8'h5A);
      rdc(8'h1A, 8'hC3);
      rdc(8'h0C, 8'h10);
      peer.send(9'h022, 8, 1'b1);
      rdc(8'h0C, 8'h10);
      wr(8'h18, 8'h80);
      wr(8'h18, 8'h90);
      rdc(8'h18, 8'h90);
      peer.send(9'h077, 8, 1'b0);
      peer.send(9'h1AB, 8, 1'b1);
      rdc(8'h18, 8'h94);
      rdc(8'h1A, 8'h77);
      rdc(8'h18, 8'h90);
      rdc(8'h1A, 8'hAB);
      // sleep holds the line idle until woken
      sleep_i <= 1'b1;
      wr(8'h19, 8'h42);
      repeat (200) @(posedge clk_i);
      chk("tx idle", 9'h001, {8'h00, tx_line});
      sleep_i <= 1'b0;
      getw(8, 9'h042);
      // abort in mid-frame releases the pin
      wr(8'h19, 8'h55);
      repeat (40) @(posedge clk_i);
      wr(8'h98, 8'h04);
      // pin enable is registered one edge behind the control write
      @(posedge clk_i);
      chk("tx enable pin", 9'h000, {8'h00, tx_pin_oe_o});
      rdc(8'h98, 8'h06);
      // low speed, divisor 1: 64 x 2 clocks per bit
      wr(8'h99, 8'h01);
      wr(8'h98, 8'h20);
      peer.bit_clks = 128;
      wr(8'h19, 8'h96);
      getw(8, 9'h096);
      tally_and_finish();
   end
endmodule
